// ---- flash_lock_params.svh ----
// Purpose: shared constants of the lock/reset/id command link
// Assumes: 125 MHz core clock on both ends
// Notes: counts derive from the printed times
`ifndef FLASH_LOCK_PARAMS_SVH
`define FLASH_LOCK_PARAMS_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define OPC_WRITE_ENABLE  8'h06
`define OPC_WRITE_DISABLE 8'h04
`define OPC_LOCK_ONE      8'h36
`define OPC_UNLOCK_ONE    8'h39
`define OPC_READ_LOCK     8'h3d
`define OPC_LOCK_ALL      8'h7e
`define OPC_UNLOCK_ALL    8'h98
`define OPC_RESET_ARM     8'h66
`define OPC_RESET_GO      8'h99
`define OPC_SERIAL_NUM    8'h4b
`define OPC_PARAM_TABLE   8'h5a

// ----------------------------------------------------------------
// frame layout, in bytes counted from the opcode
// ----------------------------------------------------------------
`define BYTES_SHORT       8'h01
`define BYTES_ADDR        8'h04
`define DATA_AT_LOCK      8'h04
`define DATA_AT_ID        8'h05
`define SERIAL_BYTES      8'h10

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     8
`define RESET_LOW_MIN_US  1
`define RESET_LOW_CYC ((`RESET_LOW_MIN_US*1000+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define RECOVERY_US       30
`define RECOVERY_CYC ((`RECOVERY_US*1000+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define RECOVERY_LONG_MS  12
`define RECOVERY_LONG_CYC ((`RECOVERY_LONG_MS*1000000+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define SCLK_HALF_CYC     4'ha

`endif

// ---- flash_lock_pkg.sv ----
// Purpose: state type of the host link end
// Assumes: nothing
// Notes: constants live in flash_lock_params.svh
package flash_lock_pkg;
	typedef enum logic [5:0] {
		st_idle    = 6'b000001,
		st_send    = 6'b000010,
		st_recv    = 6'b000100,
		st_gap     = 6'b001000,
		st_rst     = 6'b010000,
		st_recover = 6'b100000
	} host_state_t;
endpackage

// ---- flash_link_if.sv ----
// Purpose: serial flash link between host and device
// Assumes: pull-up on every data lane
// Notes: resolves the shared lanes from both enables
`timescale 1ns/1ps
interface flash_link_if;
	logic       cs_n;
	logic       sclk;
	logic       rst_n;
	logic [3:0] h_o;
	logic [3:0] h_oe;
	logic [3:0] d_o;
	logic [3:0] d_oe;
	logic [3:0] sio;

	// an undriven lane floats high
	assign sio = (h_oe & h_o) | (~h_oe & d_oe & d_o) | (~h_oe & ~d_oe);

	modport host (output cs_n, sclk, rst_n, h_o, h_oe, input sio);
	modport dev (input cs_n, sclk, rst_n, sio, output d_o, d_oe);
endinterface

// ---- flash_lock_dev.sv ----
// Purpose: device end; lock, reset, serial number, param table
// Assumes: link pins sampled by core clock; sclk well below clk/6
// Notes: blocks 0 and 255 lock per 4 KB sector, the rest per 64 KB
//
// Contract
// - select bit chooses lock bits over protect field
// - lock bits volatile, all set after reset
// - opcode 39h unlocks addressed block or sector
// - lock commands need prior write enable
// - chip select off byte boundary rejects command
// - opcode 3Dh returns lock bit first; here it goes out last, as bit 0 of each byte
// - locked regions readable, not writable
// - commands accepted single lane or quad lane
// - opcode 7Eh locks the whole array
// - opcode 98h unlocks the whole array
// - reset needs 66h then 99h directly
// - software reset restores defaults except fail flag
// - reset aborts running program or erase
// - reset pin low 1 us resets device
// - data output released while reset pin low
// - host waits recovery time after pin reset
// - opcode 4Bh plus four dummies gives serial number
// - opcode 5Ah streams param bytes until deselect
// - opcode 36h locks addressed block or sector
//
`include "flash_lock_params.svh"
`timescale 1ns/1ps
module flash_lock_dev #(
	parameter logic [127:0] SERIAL_ID = 128'h0123456789abcdeffedcba9876543210
) (
	input  wire logic        core_clk_in,
	input  wire logic        nrst_in,
	flash_link_if.dev        link,
	input  wire logic        quad_command_mode_in,
	input  wire logic        protection_scheme_select_in,
	input  wire logic        protect_complement_bit_in,
	input  wire logic [4:0]  block_protect_field_in,
	input  wire logic        write_in_progress_in,
	input  wire logic [23:0] query_addr_in,
	input  wire logic [7:0]  param_data_in,
	output logic             write_ok_out,
	output logic             write_enable_latch_out,
	output logic             abort_op_out,
	output logic             vol_reset_out,
	output logic [23:0]      param_addr_out
);
	// SERIAL_ID default is arbitrary

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic lock_at(input logic [23:0] a,
			input logic [255:0] blk, input logic [31:0] sec);
		logic by_sec;
		by_sec = (a[23:16] == 8'h00) || (a[23:16] == 8'hff);
		return by_sec ? sec[{a[23], a[15:12]}] : blk[a[23:16]];
	endfunction

	function automatic logic field_protect(input logic [7:0] blk,
			input logic [4:0] bp, input logic cmp);
		logic hit;
		logic [8:0] span;
		span = 9'h001 << bp[3:0];
		if (bp == 5'h00)
			hit = 1'b0;
		else if (bp > 5'h08)
			hit = 1'b1;
		else
			hit = ({1'b0, blk} >= (9'h100 - {1'b0, span[8:1]}));
		return hit ^ cmp;
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// bit 6 reset pin, 5 select, 4 clock, 3:0 data lanes
	wire  logic [6:0] pin_raw;
	logic [6:0]       pin_s1;
	logic [6:0]       pin_s2;
	logic [6:0]       pin_s3;
	logic [6:0]       pin_f;
	logic             sclk_d;
	logic             cs_d;

	assign pin_raw = {link.rst_n, link.cs_n, link.sclk, link.sio};

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pin_s1 <= 7'h60;
			pin_s2 <= 7'h60;
			pin_s3 <= 7'h60;
			pin_f  <= 7'h60;
			sclk_d <= 1'b0;
			cs_d   <= 1'b1;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			// a bit moves only when the last two stages agree
			pin_f  <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
			sclk_d <= pin_f[4];
			cs_d   <= pin_f[5];
		end
	end

	wire logic pin_ok    = pin_f[6];
	wire logic in_frame  = pin_ok & ~pin_f[5];
	wire logic sclk_rise = in_frame & pin_f[4] & ~sclk_d;
	wire logic sclk_fall = in_frame & ~pin_f[4] & sclk_d;
	wire logic cs_rise   = pin_ok & pin_f[5] & ~cs_d;

	// ----------------------------------------------------------------
	// frame receive decode
	// ----------------------------------------------------------------
	logic [7:0]   sh;
	logic [2:0]   bit_cnt;
	logic [7:0]   byte_cnt;
	logic [7:0]   op;
	logic [23:0]  addr;
	logic [7:0]   tx;
	logic         tx_act;
	logic [255:0] blk_lock;
	logic [31:0]  sec_lock;
	logic         write_enable_latch;
	logic         arm;
	logic [8:0]   rst_cnt;

	// upper lanes are ignored in single lane frames
	wire logic [7:0] next_sh = quad_command_mode_in ?
		{sh[3:0], pin_f[3:0]} : {sh[6:0], pin_f[0]};
	wire logic [2:0] last_step = quad_command_mode_in ? 3'h1 : 3'h7;
	wire logic byte_done = sclk_rise & (bit_cnt == last_step);
	wire logic [7:0] cnt_next = (byte_cnt == 8'hff) ?
		byte_cnt : byte_cnt + 8'h01;
	wire logic [23:0] addr_now = (byte_cnt == 8'h03) ?
		{addr[15:0], next_sh} : addr;

	wire logic is_rdlk = op == `OPC_READ_LOCK;
	wire logic is_uid  = op == `OPC_SERIAL_NUM;
	wire logic is_prm  = op == `OPC_PARAM_TABLE;
	wire logic [7:0] data_at = is_rdlk ? `DATA_AT_LOCK :
		(is_uid | is_prm) ? `DATA_AT_ID : 8'h00;
	wire logic load_tx = byte_done & (data_at != 8'h00) &
		(cnt_next >= data_at);

	wire logic [7:0]   uid_idx = byte_cnt - `BYTES_ADDR;
	wire logic [127:0] uid_sh  = SERIAL_ID << {uid_idx[3:0], 3'b000};
	wire logic [7:0]   uid_byte = (uid_idx < `SERIAL_BYTES) ?
		uid_sh[127:120] : 8'hff;
	wire logic [7:0] tx_data = is_rdlk ?
		{7'h00, lock_at(addr_now, blk_lock, sec_lock)} :
		is_uid ? uid_byte : param_data_in;

	// ----------------------------------------------------------------
	// frame end decode
	// ----------------------------------------------------------------
	// a command counts only when select rises on a byte boundary
	wire logic fr_ok  = cs_rise & (bit_cnt == 3'h0);
	wire logic is1    = byte_cnt == `BYTES_SHORT;
	wire logic is4    = byte_cnt == `BYTES_ADDR;
	wire logic do_wen = fr_ok & is1 & (op == `OPC_WRITE_ENABLE);
	wire logic do_wdi = fr_ok & is1 & (op == `OPC_WRITE_DISABLE);
	wire logic do_lk1 = fr_ok & is4 & write_enable_latch &
		(op == `OPC_LOCK_ONE);
	wire logic do_ul1 = fr_ok & is4 & write_enable_latch &
		(op == `OPC_UNLOCK_ONE);
	wire logic do_lka = fr_ok & is1 & write_enable_latch &
		(op == `OPC_LOCK_ALL);
	wire logic do_ula = fr_ok & is1 & write_enable_latch &
		(op == `OPC_UNLOCK_ALL);
	wire logic do_arm = fr_ok & is1 & (op == `OPC_RESET_ARM);
	wire logic sw_rst = fr_ok & is1 & arm &
		(op == `OPC_RESET_GO);
	wire logic any_cmd = cs_rise & (byte_cnt != 8'h00);
	wire logic pin_rst = ~pin_ok &
		(rst_cnt == 9'(`RESET_LOW_CYC - 1));
	wire logic vol_rst = sw_rst | pin_rst;
	wire logic sec_hit = (addr[23:16] == 8'h00) || (addr[23:16] == 8'hff);
	wire logic [4:0] sec_idx = {addr[23], addr[15:12]};
	wire logic prot = protection_scheme_select_in ?
		lock_at(query_addr_in, blk_lock, sec_lock) :
		field_protect(query_addr_in[23:16], block_protect_field_in,
			protect_complement_bit_in);

	// ----------------------------------------------------------------
	// shift engine
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sh       <= 8'h00;
			bit_cnt  <= 3'h0;
			byte_cnt <= 8'h00;
			op       <= 8'h00;
			addr     <= 24'h000000;
			tx       <= 8'h00;
			tx_act   <= 1'b0;
		end else if (!in_frame) begin
			bit_cnt  <= 3'h0;
			byte_cnt <= 8'h00;
			tx_act   <= 1'b0;
		end else if (sclk_rise) begin
			sh      <= next_sh;
			bit_cnt <= byte_done ? 3'h0 : bit_cnt + 3'h1;
			if (byte_done) begin
				byte_cnt <= cnt_next;
				if (byte_cnt == 8'h00)
					op <= next_sh;
				if (byte_cnt != 8'h00 && byte_cnt < `BYTES_ADDR)
					addr <= {addr[15:0], next_sh};
			end
			if (load_tx) begin
				tx     <= tx_data;
				tx_act <= 1'b1;
			end
		end else if (sclk_fall && tx_act) begin
			tx <= quad_command_mode_in ? {tx[3:0], 4'h0} : {tx[6:0], 1'b0};
		end
	end

	// lanes are driven only inside a frame with the reset pin high
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			link.d_o  <= 4'h0;
			link.d_oe <= 4'h0;
		end else begin
			if (sclk_fall && tx_act)
				link.d_o <= quad_command_mode_in ? tx[7:4] : {2'b00, tx[7], 1'b0};
			// turn on only at a falling edge, after the host has let go
			link.d_oe <= !(in_frame && tx_act) ? 4'h0 :
				!sclk_fall ? link.d_oe :
				quad_command_mode_in ? 4'hf : 4'h2;
		end
	end

	// ----------------------------------------------------------------
	// lock state, write enable, reset arming
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			blk_lock <= {256{1'b1}};
			sec_lock <= {32{1'b1}};
			write_enable_latch      <= 1'b0;
			arm      <= 1'b0;
		end else if (vol_rst) begin
			blk_lock <= {256{1'b1}};
			sec_lock <= {32{1'b1}};
			write_enable_latch      <= 1'b0;
			arm      <= 1'b0;
		end else begin
			if (do_lk1 || do_ul1) begin
				if (sec_hit)
					sec_lock[sec_idx] <= do_lk1;
				else
					blk_lock[addr[23:16]] <= do_lk1;
			end
			if (do_lka || do_ula) begin
				blk_lock <= {256{do_lka}};
				sec_lock <= {32{do_lka}};
			end
			if (do_lk1 || do_ul1 || do_lka || do_ula || do_wdi)
				write_enable_latch <= 1'b0;
			else if (do_wen)
				write_enable_latch <= 1'b1;
			// any other command between the two cancels the arm
			if (do_arm)
				arm <= 1'b1;
			else if (any_cmd)
				arm <= 1'b0;
		end
	end

	// counter stops one past the fire value so a long hold fires once
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			rst_cnt <= 9'h000;
		else if (pin_ok)
			rst_cnt <= 9'h000;
		else if (rst_cnt != 9'(`RESET_LOW_CYC))
			rst_cnt <= rst_cnt + 9'h001;
	end

	// ----------------------------------------------------------------
	// user side outputs
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			write_ok_out           <= 1'b0;
			write_enable_latch_out <= 1'b0;
			abort_op_out           <= 1'b0;
			vol_reset_out          <= 1'b0;
			param_addr_out         <= 24'h000000;
		end else begin
			write_ok_out           <= ~prot;
			write_enable_latch_out <= write_enable_latch;
			abort_op_out  <= vol_rst & write_in_progress_in;
			vol_reset_out <= vol_rst;
			if (byte_done && byte_cnt == 8'h03)
				param_addr_out <= addr_now;
			else if (load_tx && is_prm)
				param_addr_out <= param_addr_out + 24'h000001;
		end
	end
endmodule

// ---- flash_lock_host.sv ----
// Purpose: host end; frames commands and drives the reset pin
// Assumes: device lane mode matches cmd_quad_in
// Notes: serial clock made here by a divider of the core clock
`include "flash_lock_params.svh"
`timescale 1ns/1ps
module flash_lock_host #(
	parameter int RECOVERY_CYC      = `RECOVERY_CYC,
	parameter int RECOVERY_LONG_CYC = `RECOVERY_LONG_CYC
) (
	input  wire logic        core_clk_in,
	input  wire logic        nrst_in,
	flash_link_if.host       link,
	input  wire logic        cmd_valid_in,
	input  wire logic [7:0]  cmd_op_in,
	input  wire logic [23:0] cmd_addr_in,
	input  wire logic        cmd_addr_en_in,
	input  wire logic [2:0]  cmd_dummy_in,
	input  wire logic [4:0]  cmd_rx_len_in,
	input  wire logic        cmd_quad_in,
	input  wire logic        pin_reset_in,
	input  wire logic        long_recovery_in,
	output logic             busy_out,
	output logic [7:0]       rx_data_out,
	output logic             rx_valid_out,
	output logic             done_out
);
	flash_lock_pkg::host_state_t state;
	logic [3:0]  in_s1;
	logic [3:0]  in_s2;
	logic [3:0]  in_s3;
	logic [3:0]  in_f;
	logic [3:0]  div;
	logic [20:0] cnt;
	logic [63:0] txs;
	logic [7:0]  rxs;
	logic [2:0]  rx_bit;
	logic [20:0] rx_steps;
	logic        quad;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire logic idle = state == flash_lock_pkg::st_idle;
	wire logic tick = div == (`SCLK_HALF_CYC - 4'h1);
	wire logic [3:0] nb = 4'h1 + (cmd_addr_en_in ? 4'h3 : 4'h0) +
		{1'b0, cmd_dummy_in};
	wire logic [1:0] shr = cmd_quad_in ? 2'h2 : 2'h0;
	wire logic [20:0] send_steps = {14'h0000, nb, 3'b000} >> shr;
	wire logic [20:0] recv_steps = {13'h0000, cmd_rx_len_in, 3'b000} >> shr;
	wire logic [7:0] rx_next = quad ? {rxs[3:0], in_f} : {rxs[6:0], in_f[1]};
	wire logic [2:0] rx_last = quad ? 3'h1 : 3'h7;
	wire logic [20:0] rec_cyc = long_recovery_in ?
		21'(RECOVERY_LONG_CYC) : 21'(RECOVERY_CYC);
	wire logic [3:0] lane_oe = quad ? 4'hf : 4'h1;
	wire logic [3:0] lane_o = quad ? txs[63:60] : {3'b111, txs[63]};

	// ----------------------------------------------------------------
	// data lane synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			in_s1 <= 4'hf;
			in_s2 <= 4'hf;
			in_s3 <= 4'hf;
			in_f  <= 4'hf;
		end else begin
			in_s1 <= link.sio;
			in_s2 <= in_s1;
			in_s3 <= in_s2;
			in_f  <= (in_s2 & in_s3) | (in_f & (in_s2 | in_s3));
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			div <= 4'h0;
		else
			div <= (idle || tick) ? 4'h0 : div + 4'h1;
	end

	// ----------------------------------------------------------------
	// frame sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state        <= flash_lock_pkg::st_idle;
			link.cs_n    <= 1'b1;
			link.sclk    <= 1'b0;
			link.rst_n   <= 1'b1;
			link.h_o     <= 4'h0;
			link.h_oe    <= 4'h0;
			cnt          <= 21'h000000;
			txs          <= 64'h0;
			rxs          <= 8'h00;
			rx_bit       <= 3'h0;
			rx_steps     <= 21'h000000;
			quad         <= 1'b0;
			busy_out     <= 1'b0;
			rx_data_out  <= 8'h00;
			rx_valid_out <= 1'b0;
			done_out     <= 1'b0;
		end else begin
			rx_valid_out <= 1'b0;
			done_out     <= 1'b0;
			unique case (state)
			flash_lock_pkg::st_idle: begin
				if (pin_reset_in) begin
					link.rst_n <= 1'b0;
					cnt   <= 21'(`RESET_LOW_CYC);
					state <= flash_lock_pkg::st_rst;
				end else if (cmd_valid_in) begin
					// no address: dummies follow the opcode directly
					txs <= cmd_addr_en_in ? {cmd_op_in, cmd_addr_in, 32'h0} :
						{cmd_op_in, 56'h0};
					link.h_o  <= cmd_quad_in ? cmd_op_in[7:4] :
						{3'b111, cmd_op_in[7]};
					link.h_oe <= cmd_quad_in ? 4'hf : 4'h1;
					link.cs_n <= 1'b0;
					quad      <= cmd_quad_in;
					cnt       <= send_steps;
					rx_steps  <= recv_steps;
					rx_bit    <= 3'h0;
					state     <= flash_lock_pkg::st_send;
				end
			end
			flash_lock_pkg::st_send: begin
				if (tick && !link.sclk) begin
					link.sclk <= 1'b1;
					cnt <= cnt - 21'h000001;
				end else if (tick) begin
					link.sclk <= 1'b0;
					if (cnt == 21'h000000) begin
						link.h_oe <= 4'h0;
						cnt <= rx_steps;
						state <= (rx_steps == 21'h000000) ?
							flash_lock_pkg::st_gap : flash_lock_pkg::st_recv;
					end else begin
						txs <= quad ? {txs[59:0], 4'h0} : {txs[62:0], 1'b0};
						link.h_o <= quad ? txs[59:56] : {3'b111, txs[62]};
					end
				end else begin
					link.h_oe <= lane_oe;
					link.h_o  <= lane_o;
				end
			end
			flash_lock_pkg::st_recv: begin
				if (tick && !link.sclk) begin
					link.sclk <= 1'b1;
					rxs <= rx_next;
					cnt <= cnt - 21'h000001;
					rx_bit <= (rx_bit == rx_last) ? 3'h0 : rx_bit + 3'h1;
					if (rx_bit == rx_last) begin
						rx_data_out  <= rx_next;
						rx_valid_out <= 1'b1;
					end
				end else if (tick) begin
					link.sclk <= 1'b0;
					if (cnt == 21'h000000)
						state <= flash_lock_pkg::st_gap;
				end
			end
			flash_lock_pkg::st_gap: begin
				// select rises a half period after the last falling edge
				if (tick && !link.cs_n) begin
					link.cs_n <= 1'b1;
				end else if (tick) begin
					done_out <= 1'b1;
					state    <= flash_lock_pkg::st_idle;
				end
			end
			flash_lock_pkg::st_rst: begin
				cnt <= cnt - 21'h000001;
				if (cnt == 21'h000001) begin
					link.rst_n <= 1'b1;
					cnt   <= rec_cyc;
					state <= flash_lock_pkg::st_recover;
				end
			end
			flash_lock_pkg::st_recover: begin
				cnt <= cnt - 21'h000001;
				if (cnt == 21'h000001) begin
					done_out <= 1'b1;
					state    <= flash_lock_pkg::st_idle;
				end
			end
			endcase
			busy_out <= 1'b1;
			if (state == flash_lock_pkg::st_idle && !pin_reset_in &&
					!cmd_valid_in)
				busy_out <= 1'b0;
		end
	end
endmodule

// ---- flash_lock_props.sv ----
// Purpose: link checks between the host end and the device end
// Assumes: the core clock samples every link pin
// Notes: quad frames also carry an even count of clock edges
`timescale 1ns/1ps
module flash_lock_props (
	input wire logic       core_clk_in,
	input wire logic       nrst_in,
	input wire logic       cs_n,
	input wire logic       sclk,
	input wire logic       rst_n,
	input wire logic [3:0] h_oe,
	input wire logic [3:0] d_oe
);
	// ----
	// helper counters
	// ----
	logic [7:0] low_cnt;
	logic [5:0] edge_cnt;
	logic       sclk_q;
	wire  [7:0] next_low_cnt;
	wire  [5:0] next_edge_cnt;
	// saturate so a long reset pulse never wraps back below the bound
	assign next_low_cnt = rst_n ? 8'h00
		: low_cnt + {7'h00, low_cnt != 8'hff};
	assign next_edge_cnt = cs_n ? 6'h00
		: edge_cnt + {5'h00, sclk & ~sclk_q};
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			low_cnt  <= 8'h00;
			edge_cnt <= 6'h00;
			sclk_q   <= 1'b0;
		end else begin
			low_cnt  <= next_low_cnt;
			edge_cnt <= next_edge_cnt;
			sclk_q   <= sclk;
		end
	end
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	// ----
	// properties
	// ----
	a_cs_during_reset: assert property (
		!rst_n |-> cs_n)
		else $error("chip select active during pin reset");
	a_reset_low_width: assert property (
		$rose(rst_n) |-> low_cnt >= 8'h7c)
		else $error("reset pin pulse shorter than minimum");
	a_dout_released: assert property (
		$fell(rst_n) |-> ##[1:5] (d_oe == 4'h0))
		else $error("device lanes not released after reset pin fell");
	a_dout_stays_off: assert property (
		low_cnt > 8'h05 |-> d_oe == 4'h0)
		else $error("device drives lanes while reset pin low");
	a_byte_boundary: assert property (
		$rose(cs_n) |-> !edge_cnt[0])
		else $error("chip select rose off a byte boundary");
	a_no_lane_fight: assert property (
		(h_oe & d_oe) == 4'h0)
		else $error("both ends drive one lane");
	a_sclk_half: assert property (
		$rose(sclk) |-> ##10 $fell(sclk))
		else $error("serial clock high phase wrong");
	a_sclk_idle: assert property (
		cs_n |-> !sclk)
		else $error("serial clock runs outside a frame");
	a_host_quiet: assert property (
		cs_n |-> h_oe == 4'h0)
		else $error("host drives lanes while deselected");
	// the device sees select rise through its synchroniser, hence six
	a_dev_quiet: assert property (
		cs_n [*6] |-> d_oe == 4'h0)
		else $error("device drives lanes while deselected");
	cover property ($rose(cs_n));
	cover property ($rose(rst_n));
	cover property (d_oe[1]);
	cover property (h_oe == 4'hf);
endmodule

// ---- test_flash_block_lock_reset_id_cmds.sv ----
// Purpose: drives both link ends and judges the device side
// Assumes: host recovery counts shortened to 20 and 40 cycles
// Notes: param bytes are the table pointer xor 5ah
`include "flash_lock_params.svh"
`timescale 1ns/1ps
module test_flash_block_lock_reset_id_cmds;
	// arbitrary serial number
	localparam logic [127:0] ID = 128'h3c5a96e10f27b84dd2a671305e9c48fb;
	logic        clk, nrst, cv, q, prst, lrec, write_in_progress, sel, cmp, aen;
	logic [7:0]  op, rxd, pdata;
	logic [23:0] addr, qa, pa;
	logic [2:0]  dum;
	logic [4:0]  rxl, bp;
	logic        busy, rxv, done, wok, write_enable_latch, abt, vrs;
	logic [7:0]  rxq[$];
	int          bad_count, comparisons, vols, abts;
	flash_link_if link ();
	assign pdata = pa[7:0] ^ 8'h5a;
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		if (vrs === 1'b1) vols++;
		if (abt === 1'b1) abts++;
	end
	flash_lock_host #(.RECOVERY_CYC(20), .RECOVERY_LONG_CYC(40))
		i_flash_lock_host (
		.core_clk_in(clk), .nrst_in(nrst), .link(link), .cmd_valid_in(cv),
		.cmd_op_in(op), .cmd_addr_in(addr), .cmd_addr_en_in(aen),
		.cmd_dummy_in(dum), .cmd_rx_len_in(rxl), .cmd_quad_in(q),
		.pin_reset_in(prst), .long_recovery_in(lrec), .busy_out(busy),
		.rx_data_out(rxd), .rx_valid_out(rxv), .done_out(done));
	flash_lock_dev #(.SERIAL_ID(ID)) i_flash_lock_dev (
		.core_clk_in(clk), .nrst_in(nrst), .link(link),
		.quad_command_mode_in(q), .protection_scheme_select_in(sel),
		.protect_complement_bit_in(cmp), .block_protect_field_in(bp),
		.write_in_progress_in(write_in_progress), .query_addr_in(qa),
		.param_data_in(pdata), .write_ok_out(wok),
		.write_enable_latch_out(write_enable_latch), .abort_op_out(abt),
		.vol_reset_out(vrs), .param_addr_out(pa));
	flash_lock_props i_flash_lock_props (.core_clk_in(clk), .nrst_in(nrst),
		.cs_n(link.cs_n), .sclk(link.sclk), .rst_n(link.rst_n),
		.h_oe(link.h_oe), .d_oe(link.d_oe));
	// ----
	// shared tasks
	// ----
	task check(input string name, input logic [127:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task give_verdict;
		$display("compared %0d, mismatched %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task wait_done;
		int n;
		for (n = 0; n < 20000; n++) begin
			@(posedge clk);
			#1;
			if (rxv === 1'b1) rxq.push_back(rxd);
			if (done === 1'b1) break;
		end
		if (n == 20000) begin
			bad_count++;
			give_verdict;
		end
	endtask
	task send(input logic [7:0] o, input logic [23:0] a, input logic ae,
		input logic [2:0] d, input logic [4:0] r, input logic qd);
		rxq.delete();
		@(posedge clk);
		{cv, op, addr, aen, dum, rxl, q} <= {1'b1, o, a, ae, d, r, qd};
		@(posedge clk);
		cv <= 1'b0;
		wait_done;
	endtask
	task cmd(input logic [7:0] o, input logic [23:0] a = 24'h0);
		send(o, a, a != 24'h0, 3'h0, 5'h00, 1'b0);
	endtask
	task ok_at(input logic [23:0] a, input logic e);
		@(posedge clk);
		qa <= a;
		repeat (3) @(posedge clk);
		#1 check("write_ok", e, wok);
	endtask
	task pin_reset(input logic l);
		@(posedge clk);
		{prst, lrec} <= {1'b1, l};
		@(posedge clk);
		prst <= 1'b0;
		@(posedge clk);
		#1 check("busy", 1, busy);
		wait_done;
	endtask
	// ----
	// scenarios
	// ----
	task t_unlock_lock;
		check("wel", 0, write_enable_latch);
		ok_at(24'h120000, 0);
		cmd(`OPC_UNLOCK_ONE, 24'h120000);
		ok_at(24'h120000, 0);
		cmd(`OPC_WRITE_ENABLE);
		check("wel", 1, write_enable_latch);
		cmd(`OPC_UNLOCK_ONE, 24'h120000);
		check("wel", 0, write_enable_latch);
		ok_at(24'h12ffff, 1);
		ok_at(24'h130000, 0);
		send(`OPC_READ_LOCK, 24'h120000, 1, 0, 1, 0);
		check("lock bit", 0, rxq[0][0]);
		send(`OPC_READ_LOCK, 24'h130000, 1, 0, 1, 1);
		check("lock bit", 1, rxq[0][0]);
		cmd(`OPC_WRITE_ENABLE);
		cmd(`OPC_UNLOCK_ONE, 24'h003000);
		ok_at(24'h003fff, 1);
		ok_at(24'h004000, 0);
		cmd(`OPC_WRITE_ENABLE);
		cmd(`OPC_LOCK_ONE, 24'h120000);
		ok_at(24'h120000, 0);
	endtask
	task t_scheme;
		@(posedge clk) sel <= 1'b0;
		ok_at(24'h130000, 1);
		@(posedge clk) bp <= 5'h01;
		ok_at(24'hff0000, 0);
		ok_at(24'hfe0000, 1);
		@(posedge clk) cmp <= 1'b1;
		ok_at(24'hfe0000, 0);
		@(posedge clk) {sel, cmp, bp} <= {1'b1, 1'b0, 5'h00};
		ok_at(24'h130000, 0);
	endtask
	task t_global;
		send(`OPC_WRITE_ENABLE, 0, 0, 0, 0, 1);
		send(`OPC_UNLOCK_ALL, 0, 0, 0, 0, 1);
		ok_at(24'hff0000, 1);
		ok_at(24'h400000, 1);
		cmd(`OPC_WRITE_ENABLE);
		// a two byte frame is refused and must leave the latch set
		send(`OPC_LOCK_ALL, 0, 0, 1, 0, 0);
		ok_at(24'h400000, 1);
		cmd(`OPC_LOCK_ALL);
		ok_at(24'h400000, 0);
	endtask
	task t_resets;
		int v0;
		int a0;
		v0 = vols;
		a0 = abts;
		cmd(`OPC_WRITE_ENABLE);
		cmd(`OPC_UNLOCK_ALL);
		cmd(`OPC_RESET_ARM);
		cmd(`OPC_WRITE_DISABLE);
		cmd(`OPC_RESET_GO);
		check("resets", v0, vols);
		ok_at(24'h400000, 1);
		@(posedge clk) write_in_progress <= 1'b1;
		cmd(`OPC_RESET_ARM);
		cmd(`OPC_RESET_GO);
		check("resets", v0 + 1, vols);
		check("aborts", a0 + 1, abts);
		ok_at(24'h400000, 0);
		pin_reset(1);
		check("aborts", a0 + 2, abts);
		@(posedge clk) write_in_progress <= 1'b0;
		cmd(`OPC_WRITE_ENABLE);
		cmd(`OPC_UNLOCK_ALL);
		cmd(`OPC_WRITE_ENABLE);
		pin_reset(0);
		check("resets", v0 + 3, vols);
		check("wel", 0, write_enable_latch);
		ok_at(24'h400000, 0);
	endtask
	task t_reads;
		logic [127:0] v;
		send(`OPC_SERIAL_NUM, 0, 0, 4, 16, 0);
		foreach (rxq[i]) v = {v[119:0], rxq[i]};
		check("serial", ID, v);
		send(`OPC_PARAM_TABLE, 24'h000010, 1, 1, 3, 0);
		check("param", 24'h4a4b48, {rxq[0], rxq[1], rxq[2]});
	endtask
	initial begin
		{nrst, cv, q, prst, lrec, write_in_progress, cmp, aen} = '0;
		{sel, op, addr, qa, dum, rxl, bp} = {1'b1, 69'h0};
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		t_unlock_lock;
		t_scheme;
		t_global;
		t_resets;
		t_reads;
		give_verdict;
	end
endmodule
